// *** logic/ndio_ports.sv ***
/*
 * Sixteen memory-mapped 4-bit digital ports: input-only ports, push-pull
 * and open-drain I/O ports with mode registers, an 8-bit view of ports
 * 4 and 5, direct and indexed single-bit operations, software pull-up
 * enables and a filtered external interrupt pin.
 * Assumes a CPU-side master that issues one-cycle read or write strobes,
 * expects read data in the following cycle, and keeps the data memory
 * bank setup correct before port accesses. Pin inputs are synchronous.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Indexed bit operations take port low bits and bit from index register.
// - Indexed set based at port 4 sets the chosen bit in ports 4 to 7.
// - Ports 0, 1, 8 and 15 are input-only and always readable.
// - Ports 3 and 6 choose direction per bit.
// - Ports 2, 4, 5, 7 and 9 to 14 choose direction per nibble.
// - Ports 4 and 5 read and write together as one byte.
// - Mode bit 0 gives input, buffer off; 1 gives output, buffer on.
// - Mode register groups A, B and C take byte writes.
// - Reset clears every mode bit so all ports start as inputs.
// - Software pull-ups on ports 0, 1 to 3, 6, 7; none on port 0 pin 0.
// - Port 1 pin 0 feeds the interrupt through a noise filter.
// - Reads return pins for input bits and latch for output bits.
// - Nibble or byte writes load the latch; output mode drives pins.
// - Latch is undefined after a bit operation on an input-mode bit.
// - Pull-up bits 0 to 3, 6, 7 map to ports 0 to 3, 6, 7.
module ndio_ports
	import ndio_pkg::*;
#(
	parameter int unsigned FILTER_LEN = FILTER_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [DATA_W-1:0] rdata,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	output logic [NUM_PORTS*PORT_W-1:0] pin_out,
	output logic [NUM_PORTS*PORT_W-1:0] pin_oe,
	output logic [NUM_PORTS*PORT_W-1:0] pullup_on,
	output logic external_irq_level,
	output logic external_irq_rise
);

	if (FILTER_LEN < 1 || FILTER_LEN > 255) begin : g_bad_filter
		$error("ndio_ports: FILTER_LEN must be 1 to 255");
	end

	// Port numbers and bit-op fields are hard-wired to this geometry
	if (NUM_PORTS != 16 || PORT_W != 4 || DATA_W != 8) begin : g_bad_geom
		$error("ndio_ports: needs 16 ports of 4 bits and 8-bit data");
	end

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************

	// Direction bit of one port pin; input-only ports always report 0
	function automatic logic port_dir(
		input logic [3:0] p,
		input logic [1:0] b,
		input logic [7:0] ma,
		input logic [7:0] mb,
		input logic [7:0] mc
	);
		logic d;
		d = 1'b0;
		case (p)
			4'h3: d = ma[b];
			4'h6: d = ma[{1'b1, b}];
			4'h2: d = mb[0];
			4'h4: d = mb[1];
			4'h5: d = mb[2];
			4'h7: d = mb[3];
			4'h9: d = mb[5];
			4'hA: d = mc[0];
			4'hB: d = mc[1];
			4'hC: d = mc[2];
			4'hD: d = mc[3];
			4'hE: d = mc[4];
			default: d = 1'b0;
		endcase
		return d;
	endfunction

	// Pull-up enable bit that serves one port pin
	function automatic logic pull_for(
		input logic [3:0] p,
		input logic [1:0] b,
		input logic [7:0] pu
	);
		logic e;
		e = 1'b0;
		if (PULLUP_PORTS[p]) begin
			e = pu[p[2:0]];
		end
		if (p == 4'h0 && b == 2'h0) begin
			e = 1'b0;
		end
		return e;
	endfunction

	// Only ports with an output latch accept writes
	function automatic logic writable(input logic [3:0] p);
		return OUTPUT_PORTS[p];
	endfunction

	// Nibble after a single-bit operation; codes 0 and 3 change nothing,
	// so a malformed command word cannot disturb a latch
	function automatic logic [PORT_W-1:0] bit_next(
		input logic [PORT_W-1:0] old,
		input logic [1:0] b,
		input logic [1:0] op
	);
		logic [PORT_W-1:0] n;
		n = old;
		case (op)
			OP_SET: n[b] = 1'b1;
			OP_CLEAR: n[b] = 1'b0;
			default: n = old;
		endcase
		return n;
	endfunction

	// Read view of one whole port out of the per-pin view
	function automatic logic [PORT_W-1:0] nib_view(
		input logic [NUM_PORTS*PORT_W-1:0] v,
		input logic [3:0] p
	);
		return v[p*PORT_W +: PORT_W];
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [PORT_W-1:0] latch_q [NUM_PORTS];
	logic [7:0] mode_a_q;
	logic [7:0] mode_b_q;
	logic [7:0] mode_c_q;
	logic [7:0] pullup_q;
	logic [5:0] index_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;

	logic [NUM_PORTS*PORT_W-1:0] dir;
	logic [NUM_PORTS*PORT_W-1:0] view;

	logic port_hit;
	logic [3:0] port_sel;
	logic [1:0] bop_op;
	logic [3:0] bop_port;
	logic [1:0] bop_bit;
	logic [1:0] ind_op;
	logic [3:0] ind_port;
	logic [1:0] ind_bit;

	assign port_hit = (addr[11:4] == ADDR_PORT_BASE[11:4]);
	assign port_sel = addr[3:0];

	assign bop_op = wdata[BITOP_OP_LSB +: 2];
	assign bop_port = wdata[BITOP_PORT_LSB +: 4];
	assign bop_bit = wdata[1:0];

	// Indexed target: base pair of port bits, then port low bits and bit
	assign ind_op = wdata[1:0];
	assign ind_port = {index_q[INDEX_BASE_LSB +: 2],
		index_q[INDEX_PORT_LSB +: 2]};
	assign ind_bit = index_q[1:0];

	// ****************************************************************
	// Per-pin direction, read view, drivers and pull-ups
	// ****************************************************************
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		for (genvar b = 0; b < PORT_W; b++) begin : g_bit
			localparam int unsigned I = p * PORT_W + b;
			localparam logic [3:0] PN = 4'(p);
			localparam logic [1:0] BN = 2'(b);

			assign dir[I] = port_dir(PN, BN, mode_a_q, mode_b_q,
				mode_c_q);

			// Output bits read back their latch, input bits the pin
			assign view[I] = dir[I] ? latch_q[p][b] : pin_in[I];

			if (OPEN_DRAIN_PORTS[p]) begin : g_od
				// Drive only the low level; the mask pull-up or the
				// load makes the high level
				assign pin_out[I] = 1'b0;
				assign pin_oe[I] = dir[I] & ~latch_q[p][b];
			end else begin : g_pp
				assign pin_out[I] = latch_q[p][b];
				assign pin_oe[I] = dir[I];
			end

			assign pullup_on[I] = pull_for(PN, BN, pullup_q);
		end
	end

	// ****************************************************************
	// Mode registers
	// ****************************************************************

	// The mode bits of ports 8 and 15 are stored for readback only; they
	// steer nothing, so a stray 1 there cannot turn on a driver
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_a_q <= MODE_RESET;
			mode_b_q <= MODE_RESET;
			mode_c_q <= MODE_RESET;
		end else if (we) begin
			case (addr)
				ADDR_MODE_A: mode_a_q <= wdata;
				ADDR_MODE_B: mode_b_q <= wdata;
				ADDR_MODE_C: mode_c_q <= wdata;
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Pull-up enables and index register
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pullup_q <= PULLUP_RESET;
		end else if (we && addr == ADDR_PULLUP) begin
			pullup_q <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			index_q <= INDEX_RESET;
		end else if (we && addr == ADDR_INDEX) begin
			index_q <= wdata[5:0];
		end
	end

	// ****************************************************************
	// Output latches
	// ****************************************************************

	// A bit operation writes the latch bit whatever the direction; on an
	// input-mode bit software must treat the latch as undefined after it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				latch_q[i] <= LATCH_RESET;
			end
		end else if (we) begin
			if (port_hit) begin
				if (writable(port_sel)) begin
					latch_q[port_sel] <= wdata[3:0];
				end
			end else if (addr == ADDR_PAIR45) begin
				latch_q[4] <= wdata[3:0];
				latch_q[5] <= wdata[7:4];
			end else if (addr == ADDR_BITOP) begin
				if (writable(bop_port)) begin
					latch_q[bop_port] <= bit_next(latch_q[bop_port],
						bop_bit, bop_op);
				end
			end else if (addr == ADDR_IND_BITOP) begin
				if (writable(ind_port)) begin
					latch_q[ind_port] <= bit_next(latch_q[ind_port],
						ind_bit, ind_op);
				end
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Unmapped addresses and the direct bit-operation address read as zero; the indexed one returns its target bit
	always_comb begin
		rdata_d = 8'h00;
		if (port_hit) begin
			rdata_d = {4'h0, nib_view(view, port_sel)};
		end else begin
			case (addr)
				ADDR_PAIR45: rdata_d = {nib_view(view, 4'h5),
					nib_view(view, 4'h4)};
				ADDR_MODE_A: rdata_d = mode_a_q;
				ADDR_MODE_B: rdata_d = mode_b_q;
				ADDR_MODE_C: rdata_d = mode_c_q;
				ADDR_PULLUP: rdata_d = pullup_q;
				ADDR_INDEX: rdata_d = {2'h0, index_q};
				ADDR_IND_BITOP: rdata_d = {7'h00,
					view[{ind_port, ind_bit}]};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (re) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata = rdata_q;

	// ****************************************************************
	// External interrupt pin
	// ****************************************************************
	ndio_filt_if irq_if ();

	// Port 1 pin 0 stays an ordinary input bit as well
	assign irq_if.raw = pin_in[PORT_IRQ*PORT_W];

	ndio_noise_filter #(
		.LEN(FILTER_LEN)
	) u_filter (
		.clk(clk),
		.rstn(rstn),
		.fi(irq_if.filt)
	);

	assign external_irq_level = irq_if.clean;
	assign external_irq_rise = irq_if.rise;

endmodule

`default_nettype wire

// *** shared/ndio_pkg.sv ***
/*
 * Shared constants of the nibble digital I/O port block: register
 * addresses, bit-operation codes, port capability masks, reset values.
 * Assumes a 12-bit data memory address and an 8-bit CPU data path.
 */
`default_nettype none

package ndio_pkg;

	localparam int unsigned NUM_PORTS = 16;
	localparam int unsigned PORT_W = 4;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam logic [11:0] ADDR_PORT_BASE = 12'hFF0;
	localparam logic [11:0] ADDR_PAIR45 = 12'hFE4;
	localparam logic [11:0] ADDR_MODE_A = 12'hFE8;
	localparam logic [11:0] ADDR_MODE_B = 12'hFE9;
	localparam logic [11:0] ADDR_MODE_C = 12'hFEA;
	localparam logic [11:0] ADDR_PULLUP = 12'hFEB;
	localparam logic [11:0] ADDR_INDEX = 12'hFEC;
	localparam logic [11:0] ADDR_BITOP = 12'hFED;
	localparam logic [11:0] ADDR_IND_BITOP = 12'hFEE;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned BITOP_OP_LSB = 6;
	localparam int unsigned BITOP_PORT_LSB = 2;
	localparam int unsigned INDEX_PORT_LSB = 2;
	localparam int unsigned INDEX_BASE_LSB = 4;
	localparam int unsigned MODE_B_PORT8 = 4;
	localparam int unsigned MODE_C_PORT15 = 5;

	// ****************************************************************
	// Bit operation codes
	// ****************************************************************
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_SET = 2'h1;
	localparam logic [1:0] OP_CLEAR = 2'h2;

	// ****************************************************************
	// Port capabilities, one bit per port
	// ****************************************************************
	localparam logic [15:0] OUTPUT_PORTS = 16'h7EFC;
	localparam logic [15:0] OPEN_DRAIN_PORTS = 16'h7030;
	localparam logic [15:0] PULLUP_PORTS = 16'h00CF;
	localparam logic [3:0] PORT_IRQ = 4'h1;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [3:0] LATCH_RESET = 4'h0;
	localparam logic [5:0] INDEX_RESET = 6'h00;
	localparam int unsigned FILTER_CYCLES = 4;

endpackage

`default_nettype wire

// *** shared/ndio_filt_if.sv ***
/*
 * Link between the port block and its interrupt pin noise filter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface ndio_filt_if;
	logic raw;
	logic clean;
	logic rise;

	modport filt (
		input raw,
		output clean,
		output rise
	);

	modport user (
		output raw,
		input clean,
		input rise
	);
endinterface

`default_nettype wire

// *** logic/ndio_noise_filter.sv ***
/*
 * Noise filter for the external vectored interrupt pin: the clean level
 * follows the raw pin only after it has held steady for LEN cycles.
 * Assumes the raw level is already synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module ndio_noise_filter
	import ndio_pkg::*;
#(
	parameter int unsigned LEN = FILTER_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	ndio_filt_if.filt fi
);

	if (LEN < 1 || LEN > 255) begin : g_bad_len
		$error("ndio_noise_filter: LEN must be 1 to 255");
	end

	logic [7:0] cnt_q;
	logic clean_q;
	logic rise_q;

	// Count how long the raw level has differed from the clean level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
		end else if (fi.raw == clean_q) begin
			cnt_q <= 8'h00;
		end else if (cnt_q != 8'(LEN - 1)) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			cnt_q <= 8'h00;
		end
	end

	// A glitch shorter than LEN cycles restarts the count and never passes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clean_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			rise_q <= 1'b0;
			if (fi.raw != clean_q && cnt_q == 8'(LEN - 1)) begin
				clean_q <= fi.raw;
				rise_q <= fi.raw;
			end
		end
	end

	assign fi.clean = clean_q;
	assign fi.rise = rise_q;

endmodule

`default_nettype wire

// *** sim/ndio_cpu_model.sv ***
/* CPU-side register bus master for the port block bench.
   Assumes the block answers a read in the cycle after the strobe. */
`timescale 1ns/100ps
`default_nettype none
module ndio_cpu_model
	import ndio_pkg::*;
(
	input wire logic clk,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wdata,
	output logic we,
	output logic re,
	input wire logic [DATA_W-1:0] rdata
);
	// Bank setup is taken as done, so every access reaches the ports
	initial begin
		addr = 12'h000;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
	end
	// Mode groups only ever see whole-byte writes
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		// Released lines flip so stale values are never mistaken
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		addr <= ~a;
		// Read data stand only until the next edge, so take them now
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// *** sim/ndio_ports_checker.sv ***
/* Concurrent checks on the port block's outer ports.
   Assumes one clock domain and the register map of the package. */
`timescale 1ns/100ps
`default_nettype none
module ndio_ports_checker
	import ndio_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic we,
	input wire logic re,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe,
	input wire logic [NUM_PORTS*PORT_W-1:0] pullup_on,
	input wire logic external_irq_level,
	input wire logic external_irq_rise
);
	logic [7:0] wd_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) wd_q <= 8'h00;
		else wd_q <= wdata;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ********
	// Assertions
	// ********
	rdata_idle_a: assert property (!$past(re) |-> rdata == 8'h00)
		else $error("read data outside answer cycle");
	reset_off_a: assert property ($rose(rstn) |-> pin_oe == 64'h0)
		else $error("drivers on after reset");
	in_only_a: assert property (pin_oe[7:0] == 8'h00 &&
		pin_oe[35:32] == 4'h0 && pin_oe[63:60] == 4'h0)
		else $error("input-only port driven");
	od_low_a: assert property (pin_out[23:16] == 8'h00 &&
		pin_out[59:48] == 12'h000)
		else $error("open-drain pin driven high");
	nib_dir_a: assert property (pin_oe[11:8] inside {4'h0, 4'hF} &&
		pin_oe[39:36] inside {4'h0, 4'hF})
		else $error("nibble port split direction");
	mode_on_a: assert property (we && addr == ADDR_MODE_B && wdata[0]
		|=> pin_oe[11:8] == 4'hF)
		else $error("mode write did not enable port");
	bit_dir_a: assert property (we && addr == ADDR_MODE_A
		|=> pin_oe[15:12] == wd_q[3:0])
		else $error("per-bit direction wrong");
	latch_a: assert property (we && addr == 12'hFF2
		|=> pin_out[11:8] == wd_q[3:0])
		else $error("latch not loaded");
	pu_map_a: assert property (!pullup_on[0] &&
		pullup_on[63:32] == 32'h0 && pullup_on[23:16] == 8'h00)
		else $error("pull-up on wrong pin");
	pu_write_a: assert property (we && addr == ADDR_PULLUP |=>
		pullup_on[15:12] == {4{wd_q[3]}} && pullup_on[31:28] == {4{wd_q[7]}})
		else $error("pull-up bit mapping wrong");
	irq_rise_a: assert property (external_irq_rise |->
		external_irq_level && !$past(external_irq_level))
		else $error("rise pulse without level edge");
	irq_pulse_a: assert property (external_irq_rise |=> !external_irq_rise)
		else $error("rise pulse too long");
	pair_c: cover property (we && addr == ADDR_PAIR45);
	ibit_c: cover property (we && addr == ADDR_IND_BITOP);
	irq_c: cover property (external_irq_rise);
endmodule
`default_nettype wire

// *** sim/ndio_ports_tb.sv ***
/* Self-checking bench of the port block: one task per scenario.
   Assumes the CPU model drives the bus and the bench drives pins. */
`timescale 1ns/100ps
`default_nettype none
module ndio_ports_tb
	import ndio_pkg::*;
;
	logic clk;
	logic rstn;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic we;
	logic re;
	logic [DATA_W-1:0] rdata;
	logic [63:0] pin_in;
	logic [63:0] pin_out;
	logic [63:0] pin_oe;
	logic [63:0] pullup_on;
	logic irq_lvl;
	logic irq_rise;
	logic [7:0] rd_v;
	int error_cnt;
	int n_tests;
	// Short filter keeps the run brief
	ndio_ports #(.FILTER_LEN(3)) dut (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .we(we), .re(re), .rdata(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
		.external_irq_level(irq_lvl), .external_irq_rise(irq_rise));
	ndio_cpu_model cpu (.clk(clk), .addr(addr), .wdata(wdata), .we(we),
		.re(re), .rdata(rdata));
	task automatic chk4(input logic [3:0] g, input logic [3:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t nibble %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t read %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk64(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t pins %h exp %h", $time, g, e);
		end
	endtask
	task automatic t_reset();
		chk64(pin_oe, 64'h0);
		chk64(pin_out, 64'h0);
		for (int i = 0; i < 3; i++) begin
			cpu.rd(ADDR_MODE_A + 12'(i), rd_v);
			chk8(rd_v, 8'h00);
		end
		$display("test reset done");
	endtask
	task automatic t_nibble();
		cpu.wr(12'hFF2, 8'h05);
		#1;
		chk4(pin_oe[11:8], 4'h0);
		chk4(pin_out[11:8], 4'h5);
		cpu.rd(12'hFF2, rd_v);
		chk8(rd_v, 8'h0A);
		cpu.wr(ADDR_MODE_B, 8'h01);
		#1;
		chk4(pin_oe[11:8], 4'hF);
		cpu.rd(12'hFF2, rd_v);
		chk8(rd_v, 8'h05);
		$display("test nibble done");
	endtask
	task automatic t_bitdir();
		cpu.wr(ADDR_MODE_A, 8'h05);
		cpu.wr(12'hFF3, 8'h0F);
		#1;
		chk4(pin_oe[15:12], 4'h5);
		chk4(pin_out[15:12], 4'hF);
		cpu.rd(12'hFF3, rd_v);
		chk8(rd_v, 8'h0D);
		$display("test bitdir done");
	endtask
	task automatic t_inonly();
		logic [11:0] a [3] = '{12'hFF0, 12'hFF8, 12'hFFF};
		logic [3:0] v [3] = '{4'hC, 4'h3, 4'h6};
		cpu.wr(ADDR_MODE_C, 8'h00);
		for (int i = 0; i < 3; i++) begin
			cpu.wr(a[i], 8'h0F);
			cpu.rd(a[i], rd_v);
			chk8(rd_v, {4'h0, v[i]});
		end
		chk64(pin_out & 64'hF000_000F_0000_000F, 64'h0);
		// Unmapped place reads as zero
		cpu.rd(12'h000, rd_v);
		chk8(rd_v, 8'h00);
		$display("test inonly done");
	endtask
	task automatic t_pair();
		cpu.wr(ADDR_MODE_B, 8'h07);
		cpu.wr(ADDR_PAIR45, 8'hA5);
		#1;
		chk8(pin_oe[23:16], 8'h5A);
		chk8(pin_out[23:16], 8'h00);
		cpu.rd(ADDR_PAIR45, rd_v);
		chk8(rd_v, 8'hA5);
		$display("test pair done");
	endtask
	task automatic t_bitop();
		cpu.wr(ADDR_MODE_A, 8'hF5);
		cpu.wr(ADDR_MODE_B, 8'h0F);
		cpu.wr(12'hFF6, 8'h00);
		cpu.wr(ADDR_INDEX, 8'h1A);
		cpu.wr(ADDR_IND_BITOP, {6'h00, OP_SET});
		#1;
		chk4(pin_out[27:24], 4'h4);
		cpu.rd(ADDR_IND_BITOP, rd_v);
		chk8(rd_v, 8'h01);
		cpu.wr(ADDR_BITOP, {OP_CLEAR, 4'h6, 2'h2});
		#1;
		chk4(pin_out[27:24], 4'h0);
		// Top corner of the base-4 group: port 7 pin 3
		cpu.wr(ADDR_INDEX, 8'h1F);
		cpu.wr(ADDR_IND_BITOP, {6'h00, OP_SET});
		#1;
		chk4(pin_out[31:28], 4'h8);
		$display("test bitop done");
	endtask
	task automatic t_pullup();
		cpu.wr(ADDR_PULLUP, 8'hFF);
		#1;
		chk64(pullup_on, 64'h0000_0000_FF00_FFFE);
		cpu.wr(ADDR_PULLUP, 8'h41);
		#1;
		chk64(pullup_on, 64'h0000_0000_0F00_000E);
		$display("test pullup done");
	endtask
	task automatic t_irq();
		int n;
		n = 0;
		@(posedge clk);
		pin_in[4] <= 1'b1;
		// Glitch shorter than the filter length
		repeat (2) @(posedge clk);
		pin_in[4] <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk4({3'h0, irq_lvl}, 4'h0);
		@(posedge clk);
		pin_in[4] <= 1'b1;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (irq_rise === 1'b1) n++;
		end
		chk4({3'h0, irq_lvl}, 4'h1);
		chk4(4'(n), 4'h1);
		$display("test irq done");
	endtask
	task automatic t_upper();
		cpu.wr(ADDR_MODE_B, 8'h20);
		cpu.wr(ADDR_MODE_C, 8'h1F);
		cpu.wr(12'hFF9, 8'h03);
		cpu.wr(12'hFFC, 8'h06);
		// Code 3 does nothing; code 1 sets pin 0 of port 12
		cpu.wr(ADDR_BITOP, {2'h3, 4'h9, 2'h2});
		cpu.wr(ADDR_BITOP, {OP_SET, 4'hC, 2'h0});
		#1;
		chk64(pin_oe, 64'h0FF8_FFF0_0F00_5000);
		cpu.rd(12'hFF9, rd_v);
		chk8(rd_v, 8'h03);
		cpu.rd(12'hFFC, rd_v);
		chk8(rd_v, 8'h07);
		$display("test upper done");
	endtask
	task automatic t_rerst();
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		#1;
		chk64(pin_oe, 64'h0);
		chk64(pin_out, 64'h0);
		@(posedge clk);
		rstn <= 1'b1;
		cpu.rd(ADDR_MODE_C, rd_v);
		chk8(rd_v, 8'h00);
		$display("test rerst done");
	endtask
	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		pin_in = 64'h6000_0003_0000_9A0C;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_nibble();
		t_bitdir();
		t_inonly();
		t_pair();
		t_bitop();
		t_pullup();
		t_irq();
		t_upper();
		t_rerst();
		test_done();
	end
	// Scenarios need about 120 cycles; this is 10000 cycles, over eighty times that
	initial begin
		#100000;
		error_cnt++;
		test_done();
	end
endmodule
bind ndio_ports ndio_ports_checker chk (.clk, .rstn, .addr, .wdata, .we,
	.re, .rdata, .pin_in, .pin_out, .pin_oe, .pullup_on,
	.external_irq_level, .external_irq_rise);
`default_nettype wire
